/* bench/tbpwm_channel_tb.sv */
// self-checking bench for the pwm channel
`include "tbpwm_defines.svh"

module tbpwm_channel_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tbpwm_pkg::*;
    logic core_clk_i, reset_n_i, psel_i, penable_i, pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, q;
    logic pready_o, pslverr_o, err, waveform_o, waveform_oe_o, ev_o, pin;
    int miscompares, check_count, hi, ev;
    int duties[5] = '{0, 1, 13, 15, 1023};

    tbpwm_channel dut_u (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .waveform_o(waveform_o),
        .waveform_oe_o(waveform_oe_o), .postscale_event_o(ev_o));
    tbpwm_pin_model pin_u (.wave_i(waveform_o), .oe_i(waveform_oe_o),
        .pin_o(pin));

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge core_clk_i);
        psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w;
        paddr_i <= a; pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge core_clk_i);
            if (pready_o === 1'b1) break;
        end
        if (n == 20) begin
            miscompares++;
            close_out();
        end
        q = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0; penable_i <= 1'b0;
    endtask : apb

    task automatic measure(input int n);
        hi = 0;
        ev = 0;
        repeat (n) begin
            @(negedge core_clk_i);
            hi += (pin === 1'b1) ? 1 : 0;
            ev += (ev_o === 1'b1) ? 1 : 0;
        end
    endtask : measure

    // returns one clock after a cycle start, marked by the event pulse
    task automatic wait_ev();
        int n;
        for (n = 0; n < 300; n++) begin
            @(posedge core_clk_i);
            if (ev_o === 1'b1) break;
        end
        if (n == 300) begin
            miscompares++;
            close_out();
        end
    endtask : wait_ev

    task automatic set_duty(input int d);
        apb(1, `TBPWM_DUTY_LOW_OFS, 32'(d >> 2));
        apb(1, `TBPWM_MODULE_CTRL_OFS, 32'(((d & 3) << 4) | 8'h0c));
    endtask : set_duty

    task automatic t_reset();
        check(waveform_o, 1'b0);
        apb(0, `TBPWM_PERIOD_OFS, 0); check(q, 32'h0ff);
        apb(0, `TBPWM_STATUS_OFS, 0); check(q[0], 1'b1);
        apb(0, 12'h100, 0);
        check(q, 32'h0);
        check(err, 1'b1);
        $display("reset test done");
    endtask : t_reset

    task automatic t_pwm();
        int prev;
        apb(1, `TBPWM_PERIOD_OFS, 32'h3);
        apb(1, `TBPWM_DUTY_LOW_OFS, 32'h1);
        apb(1, `TBPWM_MODULE_CTRL_OFS, 32'h20);
        apb(1, `TBPWM_STATUS_OFS, 32'h0);
        apb(1, `TBPWM_TIMER_CTRL_OFS, 32'h0c);
        apb(1, `TBPWM_MODULE_CTRL_OFS, 32'h2c);
        repeat (48) @(posedge core_clk_i);
        measure(32);
        check(hi, 12);
        check(ev, 1);
        check(waveform_oe_o, 1'b1);
        apb(0, `TBPWM_DUTY_SHADOW_OFS, 0); check(q, 32'h1);
        apb(1, `TBPWM_DUTY_SHADOW_OFS, 32'h55);
        apb(0, `TBPWM_DUTY_SHADOW_OFS, 0); check(q, 32'h1);
        apb(1, `TBPWM_TIMER_CTRL_OFS, 32'h04);
        prev = 6;
        foreach (duties[i]) begin
            wait_ev();
            set_duty(duties[i]);
            apb(0, `TBPWM_DUTY_SHADOW_OFS, 0);
            check(q, 32'(prev >> 2));
            measure(32);
            measure(16);
            check(hi, duties[i] > 16 ? 16 : duties[i]);
            apb(0, `TBPWM_DUTY_SHADOW_OFS, 0);
            check(q, 32'(duties[i] >> 2));
            prev = duties[i];
        end
        $display("pwm test done");
    endtask : t_pwm

    task automatic t_prescale();
        set_duty(6);
        apb(1, `TBPWM_TIMER_CTRL_OFS, 32'h05);
        repeat (140) @(posedge core_clk_i);
        measure(64);
        check(hi, 24);
        check(ev, 1);
        apb(1, `TBPWM_TIMER_CTRL_OFS, 32'h06);
        repeat (520) @(posedge core_clk_i);
        measure(256);
        check(hi, 96);
        check(ev, 1);
        $display("prescale test done");
    endtask : t_prescale

    task automatic t_clear();
        apb(1, `TBPWM_MODULE_CTRL_OFS, 32'h0);
        measure(80);
        check(hi, 0);
        apb(1, `TBPWM_TIMER_CTRL_OFS, 32'h0);
        apb(0, `TBPWM_TIMER_VALUE_OFS, 0);
        hi = int'(q);
        repeat (40) @(posedge core_clk_i);
        apb(0, `TBPWM_TIMER_VALUE_OFS, 0); check(q, 32'(hi));
        $display("clear test done");
    endtask : t_clear

    initial begin
        miscompares = 0;
        check_count = 0;
        reset_n_i = 1'b0;
        psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
        paddr_i = 12'h000; pwdata_i = 32'h0;
        repeat (5) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        t_reset();
        t_pwm();
        t_prescale();
        t_clear();
        close_out();
    end
endmodule : tbpwm_channel_tb

/* bench/tbpwm_pin_model.sv */
// external circuit on the pwm pin with a board pull-down
module tbpwm_pin_model (
    // pin drive
    input  wire logic wave_i,
    input  wire logic oe_i,
    // resolved level
    output logic      pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // undriven pin sinks to the pull-down level
    assign pin_o = oe_i ? wave_i : 1'b0;
endmodule : tbpwm_pin_model

/* bench/tbpwm_properties.sv */
// port assertions for the pwm channel
`include "tbpwm_defines.svh"

module tbpwm_properties (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    // apb
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [31:0] prdata_o,
    input  wire logic        pready_o,
    input  wire logic        pslverr_o,
    // pin
    input  wire logic        waveform_o,
    input  wire logic        waveform_oe_o,
    input  wire logic        postscale_event_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic acc;
    logic st_wr;
    assign acc   = psel_i && penable_i && pready_o;
    assign st_wr = acc && pwrite_i && paddr_i == `TBPWM_STATUS_OFS;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence setup_s;
        psel_i && !penable_i;
    endsequence
    sequence access_s;
        psel_i && penable_i;
    endsequence

    ready_in_access_a: assert property (
        setup_s ##1 access_s |-> pready_o)
        else $error("no ready in first access cycle");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    err_with_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    err_unmapped_a: assert property (
        acc && paddr_i > `TBPWM_STATUS_OFS |-> pslverr_o)
        else $error("unmapped access not refused");
    err_mapped_a: assert property (
        acc && paddr_i <= `TBPWM_STATUS_OFS
        && paddr_i[1:0] == 2'b00 |-> !pslverr_o)
        else $error("mapped access refused");
    err_read_zero_a: assert property (
        pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
        else $error("refused read not zero");
    clear_low_a: assert property (
        acc && pwrite_i && pwdata_i[7:0] == 8'h00
        && paddr_i == `TBPWM_MODULE_CTRL_OFS |-> ##[1:2] !waveform_o)
        else $error("control clear left pin high");
    event_pulse_a: assert property (
        postscale_event_o |=> !postscale_event_o)
        else $error("postscale event not a pulse");
    oe_cause_a: assert property (
        $changed(waveform_oe_o) |-> $past(st_wr) || $past(st_wr, 2))
        else $error("pin enable changed without status write");

endmodule : tbpwm_properties

bind tbpwm_channel tbpwm_properties props_u (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .waveform_o(waveform_o),
    .waveform_oe_o(waveform_oe_o), .postscale_event_o(postscale_event_o)
);

/* common/tbpwm_defines.svh */
// register offsets, field positions, codes and reset values
`ifndef TBPWM_DEFINES_SVH
`define TBPWM_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define TBPWM_PERIOD_OFS      12'h000
`define TBPWM_DUTY_LOW_OFS    12'h004
`define TBPWM_DUTY_SHADOW_OFS 12'h008
`define TBPWM_MODULE_CTRL_OFS 12'h00c
`define TBPWM_TIMER_CTRL_OFS  12'h010
`define TBPWM_TIMER_VALUE_OFS 12'h014
`define TBPWM_STATUS_OFS      12'h018

// ****************************************
// field positions
// ****************************************
`define TBPWM_DUTY_LSB_HI     5
`define TBPWM_DUTY_LSB_LO     4
`define TBPWM_MODE_MSB        3
`define TBPWM_TIMER_ENABLE    2
`define TBPWM_PRESCALE_MSB    1
`define TBPWM_POSTSCALE_MSB   6
`define TBPWM_POSTSCALE_LSB   3

// ****************************************
// codes and reset values
// ****************************************
`define TBPWM_MODE_PWM        2'b11
`define TBPWM_PERIOD_RESET    8'hff
`define TBPWM_BYTE_RESET      8'h00

`endif

/* common/tbpwm_pkg.sv */
// types shared by the pwm channel
package tbpwm_pkg;

    typedef logic [7:0] tbpwm_byte_type;
    typedef logic [9:0] tbpwm_tenbit_type;
    typedef logic [1:0] tbpwm_prescale_type;

endpackage : tbpwm_pkg

/* src/tbpwm_channel.sv */
// ten-bit pwm channel with apb register access
// What this block does
// - ten-bit resolution pwm waveform on output pin
// - period register sets cycle length
// - timer clears on increment after period match
// - pin set at cycle start unless duty zero
// - duty low copied to shadow at match
// - postscaler never alters waveform period
// - duty is low register then control bits 5:4
// - duty writes take effect next period
// - shadow register read-only in pwm mode
// - shadow plus two-bit latch double-buffer duty
// - time base is timer plus two sub bits
// - pin cleared when duty equals time base
// - duty beyond period keeps pin high
// - zero to control forces output latch low
// - prescaler ratios 1, 4 or 16
`include "tbpwm_defines.svh"

module tbpwm_channel
    import tbpwm_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // pin
    output logic             waveform_o,
    output logic             waveform_oe_o,
    output logic             postscale_event_o
);
    import tbpwm_pkg::*;

    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    tbpwm_byte_type   period_register;
    tbpwm_byte_type   duty_low_register;
    tbpwm_byte_type   duty_shadow_register;
    logic [5:0]       module_control_register;
    logic [6:0]       period_timer_control;
    tbpwm_byte_type   period_timer;
    logic [1:0]       duty_latch;
    logic [3:0]       postscale_count;
    logic             pin_direction_bit;

    logic             acc;
    logic             wr;
    logic             hit;
    logic             pwm_mode;
    logic             run;
    logic [1:0]       sub_bits;
    logic             tick;
    tbpwm_tenbit_type time_base;
    tbpwm_tenbit_type duty_buf;
    logic             match;
    logic             cycle_start;
    logic             cycle_start_q;

    function automatic logic is_reg(input logic [11:0] a,
                                    input logic [11:0] ofs);
        is_reg = (a == ofs);
    endfunction : is_reg

    assign acc = psel_i && penable_i;
    assign wr  = acc && pwrite_i;
    assign hit = is_reg(paddr_i, `TBPWM_PERIOD_OFS)
              || is_reg(paddr_i, `TBPWM_DUTY_LOW_OFS)
              || is_reg(paddr_i, `TBPWM_DUTY_SHADOW_OFS)
              || is_reg(paddr_i, `TBPWM_MODULE_CTRL_OFS)
              || is_reg(paddr_i, `TBPWM_TIMER_CTRL_OFS)
              || is_reg(paddr_i, `TBPWM_TIMER_VALUE_OFS)
              || is_reg(paddr_i, `TBPWM_STATUS_OFS);

    assign pwm_mode = module_control_register[`TBPWM_MODE_MSB -: 2]
                   == `TBPWM_MODE_PWM;
    assign run = period_timer_control[`TBPWM_TIMER_ENABLE];

    // period register, software defined
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            period_register <= `TBPWM_PERIOD_RESET;
        end else if (wr && is_reg(paddr_i, `TBPWM_PERIOD_OFS)) begin
            period_register <= pwdata_i[7:0];
        end
    end

    // duty writes accepted any time
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            duty_low_register <= `TBPWM_BYTE_RESET;
        end else if (wr && is_reg(paddr_i, `TBPWM_DUTY_LOW_OFS)) begin
            duty_low_register <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            module_control_register <= 6'h00;
        end else if (wr && is_reg(paddr_i, `TBPWM_MODULE_CTRL_OFS)) begin
            module_control_register <= pwdata_i[5:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            period_timer_control <= 7'h00;
        end else if (wr && is_reg(paddr_i, `TBPWM_TIMER_CTRL_OFS)) begin
            period_timer_control <= pwdata_i[6:0];
        end
    end

    // pin direction: 1 = input, cleared by software
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_direction_bit <= 1'b1;
        end else if (wr && is_reg(paddr_i, `TBPWM_STATUS_OFS)) begin
            pin_direction_bit <= pwdata_i[0];
        end
    end

    // ****************************************
    // time base
    // ****************************************
    tbpwm_prescaler u_prescaler (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n),
        .run_i      (run),
        .ratio_i    (period_timer_control[`TBPWM_PRESCALE_MSB -: 2]),
        .sub_bits_o (sub_bits),
        .tick_o     (tick)
    );

    assign time_base   = {period_timer, sub_bits};
    assign duty_buf    = {duty_shadow_register, duty_latch};
    assign cycle_start = tick && (period_timer == period_register);

    // timer counts 0..period then wraps
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            period_timer <= 8'h00;
        end else if (!run) begin
            period_timer <= period_timer;
        end else if (cycle_start) begin
            period_timer <= 8'h00;
        end else if (tick) begin
            period_timer <= period_timer + 8'h01;
        end
    end

    // double buffer: copy at period match only
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            duty_shadow_register <= `TBPWM_BYTE_RESET;
        end else if (cycle_start) begin
            duty_shadow_register <= duty_low_register;
        end else if (!pwm_mode && wr
                     && is_reg(paddr_i, `TBPWM_DUTY_SHADOW_OFS)) begin
            duty_shadow_register <= pwdata_i[7:0];
        end
    end

    // hidden two-bit latch, never visible to software
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            duty_latch <= 2'b00;
        end else if (cycle_start) begin
            duty_latch <= module_control_register[
                `TBPWM_DUTY_LSB_HI:`TBPWM_DUTY_LSB_LO];
        end
    end

    // postscaler: own event only, period untouched
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            postscale_count   <= 4'h0;
            postscale_event_o <= 1'b0;
        end else if (cycle_start) begin
            if (postscale_count == period_timer_control[
                    `TBPWM_POSTSCALE_MSB:`TBPWM_POSTSCALE_LSB]) begin
                postscale_count   <= 4'h0;
                postscale_event_o <= 1'b1;
            end else begin
                postscale_count   <= postscale_count + 4'h1;
                postscale_event_o <= 1'b0;
            end
        end else begin
            postscale_event_o <= 1'b0;
        end
    end

    // ****************************************
    // waveform
    // ****************************************
    // compare against the duty value in force (new copy at cycle start)
    assign match = (duty_buf == time_base);

    // set one clock into the cycle so set and clear share one latency
    // and the high time is exactly duty times the time-base step
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cycle_start_q <= 1'b0;
        end else begin
            cycle_start_q <= cycle_start;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            waveform_o <= 1'b0;
        end else if (module_control_register == 6'h00) begin
            waveform_o <= 1'b0;
        end else if (!pwm_mode || !run) begin
            waveform_o <= 1'b0;
        end else if (cycle_start_q) begin
            // set unless the freshly loaded duty is zero
            waveform_o <= (duty_buf != 10'h000);
        end else if (match) begin
            waveform_o <= 1'b0;
        end
        // duty past period never matches, so stays high
        // ten-bit compare above
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            waveform_oe_o <= 1'b0;
        end else begin
            waveform_oe_o <= !pin_direction_bit;
        end
    end

    // ****************************************
    // apb read and answer
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= psel_i && !penable_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pslverr_o <= 1'b0;
        end else begin
            pslverr_o <= psel_i && !penable_i && !hit;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            unique case (1'b1)
                is_reg(paddr_i, `TBPWM_PERIOD_OFS):
                    prdata_o <= {24'h0, period_register};
                is_reg(paddr_i, `TBPWM_DUTY_LOW_OFS):
                    prdata_o <= {24'h0, duty_low_register};
                is_reg(paddr_i, `TBPWM_DUTY_SHADOW_OFS):
                    prdata_o <= {24'h0, duty_shadow_register};
                is_reg(paddr_i, `TBPWM_MODULE_CTRL_OFS):
                    prdata_o <= {26'h0, module_control_register};
                is_reg(paddr_i, `TBPWM_TIMER_CTRL_OFS):
                    prdata_o <= {25'h0, period_timer_control};
                is_reg(paddr_i, `TBPWM_TIMER_VALUE_OFS):
                    prdata_o <= {24'h0, period_timer};
                is_reg(paddr_i, `TBPWM_STATUS_OFS):
                    prdata_o <= {29'h0, waveform_o, pwm_mode,
                                 pin_direction_bit};
                default:
                    prdata_o <= 32'h0000_0000;
            endcase
        end
    end

endmodule : tbpwm_channel

/* src/tbpwm_prescaler.sv */
// prescaler providing the two low time-base bits and the timer tick
module tbpwm_prescaler
    import tbpwm_pkg::*;
(
    // clock and reset
    input  wire logic                         core_clk_i,
    input  wire logic                         rst_n_i,
    // control
    input  wire logic                         run_i,
    input  wire tbpwm_pkg::tbpwm_prescale_type ratio_i,
    // time base
    output logic      [1:0]                   sub_bits_o,
    output logic                              tick_o
);
    import tbpwm_pkg::*;

    logic [5:0] count;

    // free-running phase: 1:1 uses bits 1:0, 4 bits 3:2, 16 bits 5:4
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= 6'h00;
        end else if (!run_i) begin
            count <= 6'h00;
        end else begin
            count <= count + 6'h01;
        end
    end

    always_comb begin
        unique case (ratio_i)
            2'b00: begin
                sub_bits_o = count[1:0];
                tick_o     = run_i && (count[1:0] == 2'h3);
            end
            2'b01: begin
                sub_bits_o = count[3:2];
                tick_o     = run_i && (count[3:0] == 4'hf);
            end
            default: begin
                // both 1x codes divide by 16: 64 clocks per timer count
                sub_bits_o = count[5:4];
                tick_o     = run_i && (count == 6'h3f);
            end
        endcase
    end

endmodule : tbpwm_prescaler
